// [shared/cse_pkg.sv]
// constants, types and helpers shared by the status word and exception entry block
package cse_pkg;

  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned WORD_W     = 32;

  // status word field positions
  localparam int unsigned IRQ_MASK_BIT = 7;
  localparam int unsigned FIQ_MASK_BIT = 6;
  localparam int unsigned ISTATE_BIT   = 5;
  localparam int unsigned MODE_MSB     = 4;
  localparam int unsigned CTRL_MSB     = 7;
  localparam int unsigned FLAGS_LSB    = 28;
  localparam int unsigned FLAGS_MSB    = 31;
  localparam int unsigned RSVD_LSB     = 8;
  localparam int unsigned RSVD_MSB     = 27;

  // mode field encodings
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FIQ  = 5'h11;
  localparam logic [4:0] MODE_IRQ  = 5'h12;
  localparam logic [4:0] MODE_SVC  = 5'h13;
  localparam logic [4:0] MODE_ABT  = 5'h17;
  localparam logic [4:0] MODE_UND  = 5'h1B;
  localparam logic [4:0] MODE_SYS  = 5'h1F;

  // supervisor mode with both interrupt masks set, full instruction set, flags clear
  localparam logic [31:0] PSW_RESET = 32'h000000D3;

  // vector table bases and offsets
  localparam logic [31:0] VEC_BASE_LOW  = 32'h00000000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hFFFF0000;
  localparam logic [31:0] VEC_RESET     = 32'h00000000;
  localparam logic [31:0] VEC_UNDEF     = 32'h00000004;
  localparam logic [31:0] VEC_TRAP      = 32'h00000008;
  localparam logic [31:0] VEC_PABT      = 32'h0000000C;
  localparam logic [31:0] VEC_DABT      = 32'h00000010;
  localparam logic [31:0] VEC_RSVD      = 32'h00000014;
  localparam logic [31:0] VEC_IRQ       = 32'h00000018;
  localparam logic [31:0] VEC_FIQ       = 32'h0000001C;

  // register byte offsets
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CTRL   = 12'h004;
  localparam logic [11:0] REG_EXC    = 12'h008;
  localparam logic [11:0] REG_SAVED  = 12'h00C;
  localparam logic [11:0] REG_LINK   = 12'h010;
  localparam int unsigned CTRL_HIVEC_BIT = 0;
  localparam int unsigned EXC_HIVEC_BIT  = 8;

  // banked register indices
  localparam int unsigned NUM_BANKS = 6;
  localparam logic [2:0] BANK_USR = 3'h0;
  localparam logic [2:0] BANK_FIQ = 3'h1;
  localparam logic [2:0] BANK_IRQ = 3'h2;
  localparam logic [2:0] BANK_SVC = 3'h3;
  localparam logic [2:0] BANK_ABT = 3'h4;
  localparam logic [2:0] BANK_UND = 3'h5;

  // exception causes, one bit each, bit 0 the highest priority
  typedef enum logic [6:0] {
    CSE_EX_NONE  = 7'h00,
    CSE_EX_RESET = 7'h01,
    CSE_EX_DABT  = 7'h02,
    CSE_EX_FIQ   = 7'h04,
    CSE_EX_IRQ   = 7'h08,
    CSE_EX_PABT  = 7'h10,
    CSE_EX_UNDEF = 7'h20,
    CSE_EX_TRAP  = 7'h40
  } cse_cause_e;

  function automatic logic cse_mode_valid(input logic [4:0] m);
    return (m == MODE_USER) || (m == MODE_FIQ) || (m == MODE_IRQ) || (m == MODE_SVC) ||
           (m == MODE_ABT) || (m == MODE_UND) || (m == MODE_SYS);
  endfunction : cse_mode_valid

  function automatic logic [2:0] cse_mode_bank(input logic [4:0] m);
    case (m)
      MODE_FIQ: return BANK_FIQ;
      MODE_IRQ: return BANK_IRQ;
      MODE_SVC: return BANK_SVC;
      MODE_ABT: return BANK_ABT;
      MODE_UND: return BANK_UND;
      default:  return BANK_USR;
    endcase
  endfunction : cse_mode_bank

endpackage : cse_pkg

// [core/cse_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cse_pin_sync #(
  parameter bit RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic ff1, ff2, ff3, q;
  logic next_q;

  // output follows only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    next_q = (ff2 == ff3) ? ff3 : q;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      q   <= RESET_VAL;
    end else begin
      ff1 <= d_i;
      ff2 <= ff1;
      ff3 <= ff2;
      q   <= next_q;
    end
  end

  assign q_o = q;

endmodule : cse_pin_sync

// [core/cse_exc_prio.sv]
// fixed-priority picker over pending exception requests
`timescale 1ns/100ps
module cse_exc_prio
  import cse_pkg::*;
(
  input  wire logic [6:0]          req_i,
  output cse_pkg::cse_cause_e      grant_o
);

  // undefined and trap lowest, undefined picked first on a tie
  always_comb begin
    if (req_i[0])      grant_o = CSE_EX_RESET;
    else if (req_i[1]) grant_o = CSE_EX_DABT;
    else if (req_i[2]) grant_o = CSE_EX_FIQ;
    else if (req_i[3]) grant_o = CSE_EX_IRQ;
    else if (req_i[4]) grant_o = CSE_EX_PABT;
    else if (req_i[5]) grant_o = CSE_EX_UNDEF;
    else if (req_i[6]) grant_o = CSE_EX_TRAP;
    else               grant_o = CSE_EX_NONE;
  end

endmodule : cse_exc_prio

// [core/cse_core.sv]
// status word, banked state and exception entry with an APB register port
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module cse_core
  import cse_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           reset_i,
  input  wire logic [cse_pkg::APB_ADDR_W-1:0] paddr_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [cse_pkg::WORD_W-1:0]     pwdata_i,
  output logic [cse_pkg::WORD_W-1:0]          prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  input  wire logic                           irq_req_i,
  input  wire logic                           fiq_req_i,
  input  wire logic                           high_vector_select_i,
  input  wire logic                           data_abort_i,
  input  wire logic                           prefetch_abort_i,
  input  wire logic                           undef_instr_i,
  input  wire logic                           software_trap_i,
  input  wire logic [cse_pkg::WORD_W-1:0]     return_addr_i,
  input  wire logic                           alu_flags_valid_i,
  input  wire logic [3:0]                     alu_flags_i,
  input  wire logic                           cp_req_i,
  output logic                                cp_grant_o,
  output logic                                cp_fault_o,
  output logic [cse_pkg::WORD_W-1:0]          psw_o,
  output logic                                vector_valid_o,
  output logic [cse_pkg::WORD_W-1:0]          vector_addr_o,
  output logic [2:0]                          stack_bank_o
);
  import cse_pkg::*;

  // state
  logic [31:0] psw, link [NUM_BANKS], saved [NUM_BANKS];
  logic        hivec_sw, reset_pend, pend_dabt, pend_pabt, pend_undef, pend_trap;
  logic        vec_valid;
  logic [31:0] vec_addr, prdata;
  logic [2:0]  bank;
  logic        slverr;
  cse_cause_e  last_cause;

  logic [31:0] next_psw, next_link [NUM_BANKS], next_saved [NUM_BANKS];
  logic        next_hivec_sw, next_reset_pend, next_pend_dabt, next_pend_pabt;
  logic        next_pend_undef, next_pend_trap, next_vec_valid, next_slverr;
  logic [31:0] next_vec_addr, next_prdata;
  logic [2:0]  next_bank;
  cse_cause_e  next_last_cause;

  // combinational helpers
  logic        irq_s, fiq_s, hivec_pin, hivec_eff, privileged;
  logic        wr_status, wr_ctrl, setup;
  logic [6:0]  req;
  logic [4:0]  entry_mode;
  logic [31:0] entry_off, vec_base;
  cse_cause_e  grant;

  // interrupt and vector-select pins come from outside the clock domain
  cse_pin_sync #(.RESET_VAL(1'b0)) u_irq_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (irq_req_i),
    .q_o     (irq_s)
  );
  cse_pin_sync #(.RESET_VAL(1'b0)) u_fiq_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (fiq_req_i),
    .q_o     (fiq_s)
  );
  // pin expected low, still honoured if driven
  cse_pin_sync #(.RESET_VAL(1'b0)) u_hivec_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (high_vector_select_i),
    .q_o     (hivec_pin)
  );

  assign privileged = cse_mode_valid(psw[MODE_MSB:0]) && (psw[MODE_MSB:0] != MODE_USER);

  // base chosen by pin or control register
  assign hivec_eff = hivec_sw | hivec_pin;
  assign vec_base  = hivec_eff ? VEC_BASE_HIGH : VEC_BASE_LOW;

  // normal request gated by its mask
  // fast request gated by its mask
  assign req = {pend_trap | software_trap_i,
                pend_undef | undef_instr_i,
                pend_pabt | prefetch_abort_i,
                irq_s & ~psw[IRQ_MASK_BIT],
                fiq_s & ~psw[FIQ_MASK_BIT],
                pend_dabt | data_abort_i,
                reset_pend};

  cse_exc_prio u_prio (
    .req_i   (req),
    .grant_o (grant)
  );

  // entry mode and vector offset per granted cause
  always_comb begin
    entry_mode = MODE_SVC;
    entry_off  = VEC_RSVD;
    unique case (grant)
      CSE_EX_RESET: begin
        entry_mode = MODE_SVC;
        entry_off  = VEC_RESET;
      end
      CSE_EX_DABT: begin
        entry_mode = MODE_ABT;
        entry_off  = VEC_DABT;
      end
      CSE_EX_FIQ: begin
        entry_mode = MODE_FIQ;
        entry_off  = VEC_FIQ;
      end
      CSE_EX_IRQ: begin
        entry_mode = MODE_IRQ;
        entry_off  = VEC_IRQ;
      end
      CSE_EX_PABT: begin
        entry_mode = MODE_ABT;
        entry_off  = VEC_PABT;
      end
      CSE_EX_UNDEF: begin
        entry_mode = MODE_UND;
        entry_off  = VEC_UNDEF;
      end
      CSE_EX_TRAP: begin
        entry_mode = MODE_SVC;
        entry_off  = VEC_TRAP;
      end
      CSE_EX_NONE: begin
        entry_mode = psw[MODE_MSB:0];
        entry_off  = VEC_RSVD;
      end
    endcase
  end

  assign setup     = psel_i & ~penable_i;
  assign wr_status = psel_i & penable_i & pwrite_i & (paddr_i == REG_STATUS);
  assign wr_ctrl   = psel_i & penable_i & pwrite_i & (paddr_i == REG_CTRL);

  // status word, banks, pending events and vector output
  always_comb begin
    next_psw        = psw;
    next_link       = link;
    next_saved      = saved;
    next_hivec_sw   = hivec_sw;
    next_last_cause = last_cause;
    next_vec_valid  = 1'b0;
    next_vec_addr   = vec_addr;
    // a pulse arriving while its pending copy is being taken is kept, not lost
    next_reset_pend = reset_pend & (grant != CSE_EX_RESET);
    next_pend_dabt  = (grant == CSE_EX_DABT)  ? (pend_dabt & data_abort_i)      : (pend_dabt | data_abort_i);
    next_pend_pabt  = (grant == CSE_EX_PABT)  ? (pend_pabt & prefetch_abort_i)  : (pend_pabt | prefetch_abort_i);
    next_pend_undef = (grant == CSE_EX_UNDEF) ? (pend_undef & undef_instr_i)    : (pend_undef | undef_instr_i);
    next_pend_trap  = (grant == CSE_EX_TRAP)  ? (pend_trap & software_trap_i)   : (pend_trap | software_trap_i);
    if (wr_ctrl) begin
      next_hivec_sw = pwdata_i[CTRL_HIVEC_BIT];
    end
    if (wr_status) begin
      next_psw[FLAGS_MSB:FLAGS_LSB] = pwdata_i[FLAGS_MSB:FLAGS_LSB];
      // user software cannot raise its own privilege
      if (privileged && cse_mode_valid(pwdata_i[MODE_MSB:0])) begin
        next_psw[CTRL_MSB:0] = pwdata_i[CTRL_MSB:0];
      end
    end
    if (alu_flags_valid_i) begin
      next_psw[FLAGS_MSB:FLAGS_LSB] = alu_flags_i;
    end
    if (grant != CSE_EX_NONE) begin
      next_saved[cse_mode_bank(entry_mode)] = psw;
      next_link[cse_mode_bank(entry_mode)]  = return_addr_i;
      next_psw[MODE_MSB:0]    = entry_mode;
      // entry runs the full 32-bit set
      next_psw[ISTATE_BIT]    = 1'b0;
      next_psw[IRQ_MASK_BIT]  = 1'b1;
      // reset sets the fast mask too
      // fast entry sets the fast mask
      next_psw[FIQ_MASK_BIT]  = psw[FIQ_MASK_BIT] | (grant == CSE_EX_RESET) | (grant == CSE_EX_FIQ);
      next_vec_valid          = 1'b1;
      next_vec_addr           = vec_base | entry_off;
      next_last_cause         = grant;
    end
    next_psw[RSVD_MSB:RSVD_LSB] = '0;
    // stack bank follows the new mode
    next_bank = cse_mode_bank(next_psw[MODE_MSB:0]);
  end

  // read data captured in the setup cycle so it is stable through the access phase
  always_comb begin
    next_prdata = prdata;
    next_slverr = slverr;
    if (setup) begin
      next_slverr = 1'b0;
      unique case (paddr_i)
        REG_STATUS: next_prdata = psw;
        REG_CTRL:   next_prdata = {31'h00000000, hivec_sw};
        REG_EXC:    next_prdata = {23'h000000, hivec_eff, 1'b0, last_cause};
        REG_SAVED:  next_prdata = saved[bank];
        REG_LINK:   next_prdata = link[bank];
        default: begin
          next_prdata = 32'h00000000;
          next_slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      psw        <= PSW_RESET;
      hivec_sw   <= 1'b0;
      reset_pend <= 1'b1;
      pend_dabt  <= 1'b0;
      pend_pabt  <= 1'b0;
      pend_undef <= 1'b0;
      pend_trap  <= 1'b0;
      vec_valid  <= 1'b0;
      vec_addr   <= VEC_BASE_LOW;
      last_cause <= CSE_EX_NONE;
      bank       <= BANK_SVC;
      prdata     <= 32'h00000000;
      slverr     <= 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        link[i]  <= 32'h00000000;
        saved[i] <= 32'h00000000;
      end
    end else begin
      psw        <= next_psw;
      hivec_sw   <= next_hivec_sw;
      reset_pend <= next_reset_pend;
      pend_dabt  <= next_pend_dabt;
      pend_pabt  <= next_pend_pabt;
      pend_undef <= next_pend_undef;
      pend_trap  <= next_pend_trap;
      vec_valid  <= next_vec_valid;
      vec_addr   <= next_vec_addr;
      last_cause <= next_last_cause;
      bank       <= next_bank;
      prdata     <= next_prdata;
      slverr     <= next_slverr;
      link       <= next_link;
      saved      <= next_saved;
    end
  end

  // zero-wait slave; error flag only meaningful in the access phase
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata;
  assign pslverr_o = slverr;
  assign cp_grant_o = cp_req_i & privileged;
  assign cp_fault_o = cp_req_i & ~privileged;
  assign psw_o          = psw;
  assign vector_valid_o = vec_valid;
  assign vector_addr_o  = vec_addr;
  assign stack_bank_o   = bank;

  // checks on entry behaviour, reserved status bits and coprocessor access
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  irq_mask_a: assert property (vec_valid && last_cause == CSE_EX_IRQ |-> !$past(psw[IRQ_MASK_BIT]))
    else $error("normal interrupt taken while masked");
  fiq_mask_a: assert property (vec_valid && last_cause == CSE_EX_FIQ |-> !$past(psw[FIQ_MASK_BIT]))
    else $error("fast interrupt taken while masked");
  reset_entry_a: assert property (vec_valid && last_cause == CSE_EX_RESET |->
    psw[MODE_MSB:0] == MODE_SVC && psw[IRQ_MASK_BIT] && psw[FIQ_MASK_BIT] && vec_addr[4:0] == 5'h00)
    else $error("reset entry wrong");
  undef_entry_a: assert property (vec_valid && last_cause == CSE_EX_UNDEF |->
    psw[MODE_MSB:0] == MODE_UND && psw[FIQ_MASK_BIT] == $past(psw[FIQ_MASK_BIT]) && vec_addr[4:0] == 5'h04)
    else $error("undefined entry wrong");
  trap_entry_a: assert property (vec_valid && last_cause == CSE_EX_TRAP |->
    psw[MODE_MSB:0] == MODE_SVC && psw[IRQ_MASK_BIT] && vec_addr[4:0] == 5'h08)
    else $error("trap entry wrong");
  pabt_entry_a: assert property (vec_valid && last_cause == CSE_EX_PABT |->
    psw[MODE_MSB:0] == MODE_ABT && vec_addr[4:0] == 5'h0C)
    else $error("prefetch abort entry wrong");
  dabt_entry_a: assert property (vec_valid && last_cause == CSE_EX_DABT |->
    psw[MODE_MSB:0] == MODE_ABT && vec_addr[4:0] == 5'h10)
    else $error("data abort entry wrong");
  irq_entry_a: assert property (vec_valid && last_cause == CSE_EX_IRQ |->
    psw[MODE_MSB:0] == MODE_IRQ && psw[FIQ_MASK_BIT] == $past(psw[FIQ_MASK_BIT]) && vec_addr[4:0] == 5'h18)
    else $error("normal interrupt entry wrong");
  fiq_entry_a: assert property (vec_valid && last_cause == CSE_EX_FIQ |->
    psw[MODE_MSB:0] == MODE_FIQ && psw[FIQ_MASK_BIT] && vec_addr[4:0] == 5'h1C)
    else $error("fast interrupt entry wrong");
  dabt_over_fiq_a: assert property (req[1] && req[2] |=> last_cause == CSE_EX_DABT)
    else $error("data abort lost priority");
  rsvd_zero_a: assert property (psw[RSVD_MSB:RSVD_LSB] == 20'h00000)
    else $error("reserved status bits nonzero");
  user_cp_a: assert property (cp_req_i && psw[MODE_MSB:0] == MODE_USER |-> !cp_grant_o && cp_fault_o)
    else $error("user coprocessor access granted");
  save_state_a: assert property (vec_valid && last_cause != CSE_EX_RESET |->
    saved[bank] == $past(psw) && link[bank] == $past(return_addr_i))
    else $error("entry did not save state");
  bank_follow_a: assert property (vec_valid |-> bank == (
    (last_cause == CSE_EX_FIQ) ? BANK_FIQ : (last_cause == CSE_EX_IRQ) ? BANK_IRQ :
    (last_cause == CSE_EX_DABT || last_cause == CSE_EX_PABT) ? BANK_ABT :
    (last_cause == CSE_EX_UNDEF) ? BANK_UND : BANK_SVC))
    else $error("stack bank mismatch");

  irq_take_c: cover property (vec_valid && last_cause == CSE_EX_IRQ);
  fiq_take_c: cover property (vec_valid && last_cause == CSE_EX_FIQ);
  trap_take_c: cover property (vec_valid && last_cause == CSE_EX_TRAP);
  nested_c: cover property (vec_valid ##1 vec_valid);

endmodule : cse_core

// [sim/cse_exc_src.sv]
// model of the interrupt sources and memory system facing the exception block
`timescale 1ns/100ps
module cse_exc_src (
  input  wire logic        clk_i,
  output logic             irq_req_o,
  output logic             fiq_req_o,
  output logic             high_vector_select_o,
  output logic             data_abort_o,
  output logic             prefetch_abort_o,
  output logic             undef_instr_o,
  output logic             software_trap_o,
  output logic [31:0]      return_addr_o
);
  // quiet sources at time zero
  initial begin
    irq_req_o        = 1'b0;
    fiq_req_o        = 1'b0;
    data_abort_o     = 1'b0;
    prefetch_abort_o = 1'b0;
    undef_instr_o    = 1'b0;
    software_trap_o  = 1'b0;
    return_addr_o    = 32'h00000000;
  end

  // select held low
  // no memory sits at the high table, so the pin stays deasserted
  assign high_vector_select_o = 1'b0;

  // pulses last one cycle, interrupt levels stay until lowered
  task automatic fire(input logic [5:0] m, input logic [31:0] ra);
    @(posedge clk_i);
    {fiq_req_o, irq_req_o} <= {fiq_req_o, irq_req_o} | m[5:4];
    {data_abort_o, prefetch_abort_o, undef_instr_o, software_trap_o} <= m[3:0];
    return_addr_o <= ra;
    @(posedge clk_i);
    {data_abort_o, prefetch_abort_o, undef_instr_o, software_trap_o} <= 4'h0;
  endtask : fire

  // drop both interrupt levels
  task automatic lower();
    @(posedge clk_i);
    irq_req_o <= 1'b0;
    fiq_req_o <= 1'b0;
  endtask : lower
endmodule : cse_exc_src

// [sim/cse_core_tb.sv]
// self-checking bench for the status word and exception entry block
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  comparisons++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end
module cse_core_tb;
  import cse_pkg::*;
  logic clk_i, reset_i, psel, penable, pwrite, alu_v, cp_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_o, psw_o, vaddr, ra, q;
  logic pready_o, pslverr_o, vv, grant, fault, e;
  logic irq, fast_interrupt, hv, dabt, pabt, und, trap;
  logic [3:0] flags;
  logic [2:0] bank;
  int errors, comparisons, c;
  logic [31:0] tbl [6] = '{32'h01089303, 32'h02049B05, 32'h040C9704,
                           32'h08109704, 32'h10189202, 32'h201CD101};
  logic [7:0] prio [4] = '{8'h10, 8'h0C, 8'h04, 8'h08};

  cse_core dut_u (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_req_i(irq), .fiq_req_i(fast_interrupt),
    .high_vector_select_i(hv), .data_abort_i(dabt), .prefetch_abort_i(pabt),
    .undef_instr_i(und), .software_trap_i(trap), .return_addr_i(ra),
    .alu_flags_valid_i(alu_v), .alu_flags_i(flags), .cp_req_i(cp_req),
    .cp_grant_o(grant), .cp_fault_o(fault), .psw_o(psw_o), .vector_valid_o(vv),
    .vector_addr_o(vaddr), .stack_bank_o(bank));

  cse_exc_src src_u (.clk_i(clk_i), .irq_req_o(irq), .fiq_req_o(fast_interrupt),
    .high_vector_select_o(hv), .data_abort_o(dabt), .prefetch_abort_o(pabt),
    .undef_instr_o(und), .software_trap_o(trap), .return_addr_o(ra));

  // 200 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // one apb transfer, held until pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
    // zero-wait slave: the access ends at its first edge
    `CHK("apb_wait", 1, n)
  endtask : apb

  // wait for the entry pulse under a bound
  task automatic wait_vec();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 30 && !seen; i++) begin
      @(posedge clk_i);
      seen = (vv === 1'b1);
    end
    `CHK("entry_seen", 1'b1, seen)
  endtask : wait_vec

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    alu_v = 1'b0;
    flags = 4'h0;
    cp_req = 1'b0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    wait_vec();
    `CHK("reset_vec", 32'h00000000, vaddr)
    `CHK("reset_psw", 32'h000000D3, psw_o)
    `CHK("reset_bank", 3'h3, bank)
    // each exception but reset from supervisor with both masks clear
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, REG_STATUS, 32'h00000013);
      src_u.fire(tbl[i][29:24], 32'h00002000 + i);
      wait_vec();
      `CHK("entry_vec", {24'h0, tbl[i][23:16]}, vaddr)
      `CHK("entry_psw", tbl[i][15:8], psw_o[7:0])
      `CHK("entry_bank", tbl[i][2:0], bank)
      src_u.lower();
      apb(1'b0, REG_LINK, 32'h0);
      `CHK("link", 32'h00002000 + i, q)
      apb(1'b0, REG_SAVED, 32'h0);
      `CHK("saved", 32'h00000013, q)
    end
    // both levels held while both masks are set
    apb(1'b1, REG_STATUS, 32'h000000D3);
    src_u.fire(6'h30, 32'h0);
    c = 0;
    repeat (12) begin
      @(posedge clk_i);
      c += (vv === 1'b1);
    end
    `CHK("masked_cnt", 0, c)
    apb(1'b1, REG_STATUS, 32'h00000053);
    wait_vec();
    `CHK("unmask_vec", 32'h00000018, vaddr)
    `CHK("unmask_psw", 8'hD2, psw_o[7:0])
    src_u.lower();
    // four pulses together leave in priority order
    src_u.fire(6'h0F, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wait_vec();
      `CHK("prio_vec", {24'h0, prio[i]}, vaddr)
    end
    // data abort and an unmasked fast request reach the picker in the same cycle
    apb(1'b1, REG_STATUS, 32'h00000093);
    src_u.fire(6'h20, 32'h0);
    repeat (2) @(posedge clk_i);
    src_u.fire(6'h08, 32'h00003000);
    wait_vec();
    `CHK("dabt_first", 32'h00000010, vaddr)
    wait_vec();
    `CHK("fiq_second", 32'h0000001C, vaddr)
    src_u.lower();
    // software high table select
    apb(1'b1, REG_CTRL, 32'h00000001);
    src_u.fire(6'h02, 32'h0);
    wait_vec();
    `CHK("hi_vec", 32'hFFFF0004, vaddr)
    apb(1'b0, REG_EXC, 32'h0);
    `CHK("exc_status", 32'h00000120, q)
    apb(1'b1, REG_CTRL, 32'h00000000);
    // reserved bits and instruction state
    apb(1'b1, REG_STATUS, 32'h0FFFFF33);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("rsvd_read", 32'h00000033, q)
    `CHK("istate", 1'b1, psw_o[5])
    @(posedge clk_i);
    alu_v <= 1'b1;
    flags <= 4'hA;
    @(posedge clk_i);
    alu_v <= 1'b0;
    @(negedge clk_i);
    `CHK("flags", 4'hA, psw_o[31:28])
    // coprocessor access and user mode restrictions
    @(posedge clk_i);
    cp_req <= 1'b1;
    @(negedge clk_i);
    `CHK("cp_priv", 2'b10, {grant, fault})
    apb(1'b1, REG_STATUS, 32'h00000010);
    @(negedge clk_i);
    `CHK("cp_user", 2'b01, {grant, fault})
    apb(1'b1, REG_STATUS, 32'h00000013);
    `CHK("user_stuck", 5'h10, psw_o[4:0])
    src_u.fire(6'h01, 32'h0);
    wait_vec();
    `CHK("trap_svc", MODE_SVC, psw_o[4:0])
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 33'h100000000, {e, q})
    print_verdict();
  end
endmodule : cse_core_tb
